/* File: logic/gvi_regs.vh */
// Constants for one grouped vectored interrupt controller group.
// Assumes inclusion by bare name from the design files.
`ifndef GVI_REGS_VH
`define GVI_REGS_VH

// Clock and request qualification
`define GVI_CLK_PERIOD_NS 5
`define GVI_REQ_MIN_NS 10
// Two clocks cover the minimum width; sized to fit the qualifier counter
`define GVI_REQ_MIN_CYC 4'h2

// Mode register bit positions
`define GVI_MODE_ROTATE 0
`define GVI_MODE_COMMON 1
`define GVI_MODE_POLLED 2
`define GVI_MODE_RDSEL_LO 5
`define GVI_MODE_RDSEL_HI 6
`define GVI_MODE_ARM 7
`define GVI_MODE_RESET 8'h00

// Status register bit positions
`define GVI_STAT_INT 7
`define GVI_STAT_CHAIN 6
`define GVI_STAT_ROT 5
`define GVI_STAT_POLL 4
`define GVI_STAT_ARM 3

// Reset values
`define GVI_MASK_RESET 8'hff
`define GVI_LATCH_RESET 8'h00
`define GVI_SERV_RESET 8'h00
`define GVI_ACLR_RESET 8'h00
`define GVI_ROT_RESET 3'h7

// Command opcodes, field cmd[7:5]
`define GVI_CMD_RESET 8'h00
`define GVI_OP_MODE_LOW 3'h1
`define GVI_OP_RDSEL 3'h2
`define GVI_OP_ARM 3'h3
`define GVI_OP_MASK 3'h4
`define GVI_OP_LATCH 3'h5
`define GVI_OP_PRESEL 3'h6
`define GVI_OP_SERV 3'h7

// Sub-operations, field cmd[4:3]
`define GVI_SUB_CLR_ALL 2'h0
`define GVI_SUB_SET_ALL 2'h1
`define GVI_SUB_CLR_BIT 2'h2
`define GVI_SUB_SET_BIT 2'h3

// Read selects, mode bits 6:5
`define GVI_RD_SERV 2'h0
`define GVI_RD_MASK 2'h1
`define GVI_RD_LATCH 2'h2
`define GVI_RD_ACLR 2'h3

// Data port targets
`define GVI_PS_NONE 2'h0
`define GVI_PS_MASK 2'h1
`define GVI_PS_ACLR 2'h2
`define GVI_PS_VECT 2'h3

`endif

/* File: logic/gvi_req_qual.v */
// Qualifies one interrupt request line: one pulse per wide enough rising request.
// Assumes the request line is synchronous to the system clock, active high.
`timescale 1ns/1ps
`include "gvi_regs.vh"

module gvi_req_qual #(
	parameter [3:0] MIN_CYC = 4'h2
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_srst,
	// Request line
	input wire i_req,
	// Qualified event
	output wire o_event
);

reg [3:0] width_ff;
reg armed_ff;
reg event_ff;

// A line must fall back inactive before it can count again
always @(posedge i_clk_sys) begin
	if (i_srst) begin
		width_ff <= 4'h0;
		armed_ff <= 1'b1;
		event_ff <= 1'b0;
	end else if (!i_req) begin
		width_ff <= 4'h0;
		armed_ff <= 1'b1;
		event_ff <= 1'b0;
	end else begin
		width_ff <= (width_ff == MIN_CYC) ? width_ff : width_ff + 4'h1;
		event_ff <= armed_ff && (width_ff + 4'h1 == MIN_CYC);
		if (width_ff + 4'h1 == MIN_CYC) begin
			armed_ff <= 1'b0;
		end
	end
end

assign o_event = event_ff;

endmodule // gvi_req_qual

/* File: logic/gvi_group.v */
// One eight-input vectored interrupt controller group with its register set.
// Assumes one system clock, a host using one-cycle read and write strobes,
// and request lines already synchronous and active high.
`timescale 1ns/1ps
`include "gvi_regs.vh"

module gvi_group (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_srst,
	// Host port
	input wire i_port_select,
	input wire i_rd_en,
	input wire i_wr_en,
	input wire [7:0] i_wdata,
	output wire [7:0] o_rdata,
	// Acknowledge
	input wire i_acknowledge_strobe,
	output wire [7:0] o_vector,
	output wire o_vector_valid,
	// Requests and group control
	input wire [7:0] i_irq,
	input wire i_chain_enable_in,
	input wire i_interrupt_enable_bit,
	output wire o_group_interrupt_out
);

////////////////////////////////////////////////////////////////////////////////
// State

reg [7:0] group_command_ff;
reg [7:0] group_mode_ff;
reg [7:0] request_latch_ff;
reg [7:0] in_service_ff;
reg [7:0] request_mask_ff;
reg [7:0] auto_clear_select_ff;
reg [1:0] presel_ff;
reg [2:0] vect_level_ff;
reg [2:0] rot_last_ff;
reg [7:0] rdata_ff;
reg [7:0] vector_ff;
reg vector_valid_ff;
reg [7:0] vect_mem [0:7];

reg [7:0] nxt_mode;
reg [7:0] nxt_latch;
reg [7:0] nxt_serv;
reg [7:0] nxt_mask;
reg [7:0] nxt_aclr;
reg [1:0] nxt_presel;
reg [2:0] nxt_vect_level;
reg [2:0] nxt_rot_last;

wire [7:0] req_event;
wire cmd_wr;
wire data_wr;
wire data_rd;
wire ctrl_rd;
wire [2:0] op;
wire [1:0] sub;
wire [7:0] bit_sel;

////////////////////////////////////////////////////////////////////////////////
// Request qualification

genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_qual
		gvi_req_qual #(
			.MIN_CYC(`GVI_REQ_MIN_CYC)
		) u_qual (
			.i_clk_sys(i_clk_sys),
			.i_srst(i_srst),
			.i_req(i_irq[gi]),
			.o_event(req_event[gi])
		);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Priority and fence

// Fixed fence: level i passes only if no service bit at i or above in priority
function [7:0] fixed_fence;
	input [7:0] serv;
	integer k;
	reg blk;
	begin
		blk = 1'b0;
		fixed_fence = 8'h00;
		for (k = 0; k < 8; k = k + 1) begin
			blk = blk | serv[k];
			fixed_fence[k] = ~blk;
		end
	end
endfunction

// Winner search from a start level: just after the most recently serviced level in rotate mode, level 0 otherwise
function [3:0] pick;
	input [7:0] cand;
	input [2:0] start;
	integer k;
	reg [2:0] idx;
	begin
		pick = 4'h0;
		for (k = 7; k >= 0; k = k - 1) begin
			idx = start + k[2:0];
			if (cand[idx]) begin
				pick = {1'b1, idx};
			end
		end
	end
endfunction

wire rotate = group_mode_ff[`GVI_MODE_ROTATE];
wire polled = group_mode_ff[`GVI_MODE_POLLED];
wire armed = group_mode_ff[`GVI_MODE_ARM];
wire [7:0] fence = rotate ? {8{~|in_service_ff}} : fixed_fence(in_service_ff);
wire [7:0] candidates = request_latch_ff & ~request_mask_ff & fence;
wire [2:0] search_start = rotate ? rot_last_ff + 3'h1 : 3'h0;
wire [3:0] winner = pick(candidates, search_start);
wire group_pending = (|candidates) & i_chain_enable_in & armed & i_interrupt_enable_bit;
// Polled mode only silences the pin; status still shows pending work
wire group_int = group_pending & ~polled;
wire ack_take = i_acknowledge_strobe & i_chain_enable_in & winner[3];

////////////////////////////////////////////////////////////////////////////////
// Host decode

assign cmd_wr = i_wr_en & i_port_select;
assign data_wr = i_wr_en & ~i_port_select;
assign ctrl_rd = i_rd_en & i_port_select;
assign data_rd = i_rd_en & ~i_port_select;
assign op = group_command_ff[7:5];
assign sub = i_wdata[4:3];
assign bit_sel = 8'h01 << i_wdata[2:0];

always @* begin
	nxt_mode = group_mode_ff;
	nxt_latch = request_latch_ff;
	nxt_serv = in_service_ff;
	nxt_mask = request_mask_ff;
	nxt_aclr = auto_clear_select_ff;
	nxt_presel = presel_ff;
	nxt_vect_level = vect_level_ff;
	nxt_rot_last = rot_last_ff;
	if (cmd_wr) begin
		if (i_wdata == `GVI_CMD_RESET) begin
			nxt_mode = `GVI_MODE_RESET;
			nxt_latch = `GVI_LATCH_RESET;
			nxt_serv = `GVI_SERV_RESET;
			nxt_mask = `GVI_MASK_RESET;
			nxt_aclr = `GVI_ACLR_RESET;
			nxt_presel = `GVI_PS_NONE;
			nxt_rot_last = `GVI_ROT_RESET;
		end else begin
			case (i_wdata[7:5])
			`GVI_OP_MODE_LOW: begin
				nxt_mode[4:0] = i_wdata[4:0];
			end
			`GVI_OP_RDSEL: begin
				nxt_mode[`GVI_MODE_RDSEL_HI:`GVI_MODE_RDSEL_LO] = i_wdata[1:0];
			end
			`GVI_OP_ARM: begin
				nxt_mode[`GVI_MODE_ARM] = i_wdata[0];
			end
			`GVI_OP_MASK: begin
				case (sub)
				`GVI_SUB_CLR_ALL: nxt_mask = 8'h00;
				`GVI_SUB_SET_ALL: nxt_mask = 8'hff;
				`GVI_SUB_CLR_BIT: nxt_mask = request_mask_ff & ~bit_sel;
				default: nxt_mask = request_mask_ff | bit_sel;
				endcase
			end
			`GVI_OP_LATCH: begin
				case (sub)
				`GVI_SUB_CLR_ALL: nxt_latch = 8'h00;
				`GVI_SUB_SET_ALL: nxt_latch = 8'hff;
				`GVI_SUB_CLR_BIT: nxt_latch = request_latch_ff & ~bit_sel;
				default: nxt_latch = request_latch_ff | bit_sel;
				endcase
			end
			`GVI_OP_PRESEL: begin
				case (sub)
				`GVI_SUB_CLR_ALL: nxt_presel = `GVI_PS_MASK;
				`GVI_SUB_SET_ALL: nxt_presel = `GVI_PS_ACLR;
				default: begin
					nxt_presel = `GVI_PS_VECT;
					nxt_vect_level = i_wdata[2:0];
				end
				endcase
			end
			default: begin
				// Service bit clear, all or one level; fence drops back
				if (i_wdata[3]) begin
					nxt_serv = in_service_ff & ~bit_sel;
				end else begin
					nxt_serv = 8'h00;
				end
			end
			endcase
		end
	end else if (data_wr) begin
		if (presel_ff == `GVI_PS_MASK) begin
			nxt_mask = i_wdata;
		end else if (presel_ff == `GVI_PS_ACLR) begin
			nxt_aclr = i_wdata;
		end else if (presel_ff == `GVI_PS_VECT) begin
			// One byte per preselect; a second write is dropped
			nxt_presel = `GVI_PS_NONE;
		end
	end
	// Hardware sets come last so a same-cycle clear loses no event, except under the reset command
	if (!(cmd_wr && i_wdata == `GVI_CMD_RESET)) begin
		nxt_latch = nxt_latch | req_event;
		if (ack_take) begin
			nxt_latch[winner[2:0]] = req_event[winner[2:0]];
			nxt_serv[winner[2:0]] = ~auto_clear_select_ff[winner[2:0]];
			if (rotate) begin
				nxt_rot_last = winner[2:0];
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registers

always @(posedge i_clk_sys) begin
	if (i_srst) begin
		group_command_ff <= `GVI_CMD_RESET;
		group_mode_ff <= `GVI_MODE_RESET;
		request_latch_ff <= `GVI_LATCH_RESET;
		in_service_ff <= `GVI_SERV_RESET;
		request_mask_ff <= `GVI_MASK_RESET;
		auto_clear_select_ff <= `GVI_ACLR_RESET;
		presel_ff <= `GVI_PS_NONE;
		vect_level_ff <= 3'h0;
		rot_last_ff <= `GVI_ROT_RESET;
	end else begin
		if (cmd_wr) begin
			group_command_ff <= i_wdata;
		end
		group_mode_ff <= nxt_mode;
		request_latch_ff <= nxt_latch;
		in_service_ff <= nxt_serv;
		request_mask_ff <= nxt_mask;
		auto_clear_select_ff <= nxt_aclr;
		presel_ff <= nxt_presel;
		vect_level_ff <= nxt_vect_level;
		rot_last_ff <= nxt_rot_last;
	end
end

// Vector store keeps its contents through software and power-up reset
always @(posedge i_clk_sys) begin
	if (data_wr && presel_ff == `GVI_PS_VECT) begin
		vect_mem[vect_level_ff] <= i_wdata;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read and acknowledge answers

wire [7:0] status = {group_pending, i_chain_enable_in, rotate, polled, armed, 3'b000};

always @(posedge i_clk_sys) begin
	if (i_srst) begin
		rdata_ff <= 8'h00;
		vector_ff <= 8'h00;
		vector_valid_ff <= 1'b0;
	end else begin
		if (ctrl_rd) begin
			rdata_ff <= status;
		end else if (data_rd) begin
			// Vector store is never offered here
			case (group_mode_ff[`GVI_MODE_RDSEL_HI:`GVI_MODE_RDSEL_LO])
			`GVI_RD_SERV: rdata_ff <= in_service_ff;
			`GVI_RD_MASK: rdata_ff <= request_mask_ff;
			`GVI_RD_LATCH: rdata_ff <= request_latch_ff;
			default: rdata_ff <= auto_clear_select_ff;
			endcase
		end
		vector_valid_ff <= ack_take;
		if (ack_take) begin
			vector_ff <= group_mode_ff[`GVI_MODE_COMMON] ? vect_mem[0] : vect_mem[winner[2:0]];
		end
	end
end

assign o_rdata = rdata_ff;
assign o_vector = vector_ff;
assign o_vector_valid = vector_valid_ff;
assign o_group_interrupt_out = group_int;

endmodule // gvi_group

/* File: tb/gvi_group_sva.sv */
// Port checker for gvi_group.
// Assumes it is bound to every gvi_group instance.
`timescale 1ns/1ps
module gvi_group_sva (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_srst,
	// Watched ports
	input wire i_port_select,
	input wire i_rd_en,
	input wire [7:0] o_rdata,
	input wire i_acknowledge_strobe,
	input wire [7:0] o_vector,
	input wire o_vector_valid,
	input wire i_chain_enable_in,
	input wire i_interrupt_enable_bit,
	input wire o_group_interrupt_out
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	////////////////////////////////////////
	sequence stat_rd;
		i_rd_en && i_port_select;
	endsequence
	sequence ack_in;
		i_acknowledge_strobe && i_chain_enable_in;
	endsequence
	group_interrupt_out_ie_a: assert property (o_group_interrupt_out |-> i_interrupt_enable_bit)
		else $error("group interrupt without enable bit");
	group_interrupt_out_chain_a: assert property (o_group_interrupt_out |-> i_chain_enable_in)
		else $error("group interrupt without chain enable");
	stat_int_a: assert property (stat_rd |=> (o_rdata[4] || o_rdata[7] == $past(o_group_interrupt_out)))
		else $error("status interrupt bit wrong");
	poll_quiet_a: assert property (stat_rd ##1 o_rdata[4] |-> !$past(o_group_interrupt_out))
		else $error("group interrupt active in polled mode");
	stat_chain_a: assert property (stat_rd |=> o_rdata[6] == $past(i_chain_enable_in))
		else $error("status chain bit wrong");
	valid_cause_a: assert property (o_vector_valid |-> $past(i_acknowledge_strobe && i_chain_enable_in))
		else $error("vector valid without acknowledge");
	vector_hold_a: assert property (!o_vector_valid |-> $stable(o_vector))
		else $error("vector changed outside acknowledge");
	rdata_hold_a: assert property (!$past(i_rd_en) |-> $stable(o_rdata))
		else $error("read data changed without read");
	reset_clear_a: assert property ($fell(i_srst) |-> !o_group_interrupt_out && !o_vector_valid)
		else $error("outputs active after reset");
	ack_c: cover property (ack_in ##1 o_vector_valid);
endmodule // gvi_group_sva

bind gvi_group gvi_group_sva gvi_group_sva_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
	.i_port_select(i_port_select), .i_rd_en(i_rd_en), .o_rdata(o_rdata),
	.i_acknowledge_strobe(i_acknowledge_strobe), .o_vector(o_vector), .o_vector_valid(o_vector_valid),
	.i_chain_enable_in(i_chain_enable_in), .i_interrupt_enable_bit(i_interrupt_enable_bit),
	.o_group_interrupt_out(o_group_interrupt_out));

/* File: tb/gvi_host_model.sv */
// Host processor model: control and data port cycles.
// Assumes the bench calls its tasks; lines change at the falling edge.
`timescale 1ns/1ps
module gvi_host_model (
	// Clock
	input wire i_clk_sys,
	// Host port
	output reg o_port_select,
	output reg o_rd_en,
	output reg o_wr_en,
	output reg [7:0] o_wdata,
	input wire [7:0] i_rdata
);
	initial begin
		o_port_select = 1'b0;
		o_rd_en = 1'b0;
		o_wr_en = 1'b0;
		o_wdata = 8'h00;
	end
	task wr(input reg ps, input reg [7:0] d);
		@(negedge i_clk_sys);
		o_port_select = ps;
		o_wdata = d;
		o_wr_en = 1'b1;
		@(negedge i_clk_sys);
		o_wr_en = 1'b0;
		o_wdata = ~d; // Bus set to the inverse of the last byte, not a stale copy
	endtask
	task rd(input reg ps, output reg [7:0] d);
		@(negedge i_clk_sys);
		o_port_select = ps;
		o_rd_en = 1'b1;
		@(negedge i_clk_sys);
		o_rd_en = 1'b0;
		d = i_rdata;
	endtask
	// Fresh preselect for every byte, byte count one
	task vect(input reg [2:0] n, input reg [7:0] v);
		wr(1'b1, {5'b1101_0, n});
		wr(1'b0, v);
	endtask
endmodule // gvi_host_model

/* File: tb/test_gvi_group.sv */
// Self-checking bench for gvi_group.
// Assumes the host model and bound checker are compiled first.
`timescale 1ns/1ps
module test_gvi_group;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg ack = 1'b0;
	reg chain = 1'b1;
	reg ie = 1'b1;
	reg [7:0] irq = 8'h00;
	wire ps, rd, wr, vld, group_interrupt_out;
	wire [7:0] wdata, rdata, vec;
	reg [7:0] vmem [0:7];
	reg [7:0] pend, d;
	reg [2:0] t;
	integer n_errors = 0, n_compared = 0, cyc = 0, i;
	always #2.5 clk = ~clk;
	gvi_group gvi_group_i (.i_clk_sys(clk), .i_srst(srst), .i_port_select(ps), .i_rd_en(rd),
		.i_wr_en(wr), .i_wdata(wdata), .o_rdata(rdata), .i_acknowledge_strobe(ack), .o_vector(vec),
		.o_vector_valid(vld), .i_irq(irq), .i_chain_enable_in(chain), .i_interrupt_enable_bit(ie),
		.o_group_interrupt_out(group_interrupt_out));
	gvi_host_model gvi_host_model_i (.i_clk_sys(clk), .o_port_select(ps), .o_rd_en(rd),
		.o_wr_en(wr), .o_wdata(wdata), .i_rdata(rdata));
	////////////////////////////////////////
	task chk(input string nm, input [7:0] seen, input [7:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("Error %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function [2:0] top(input [7:0] p);
		for (top = 3'd7; p[top] == 1'b0 && top != 3'd0; top = top - 3'd1) begin
		end
		for (int j = 7; j >= 0; j--) begin
			if (p[j]) top = j[2:0];
		end
	endfunction
	task rdreg(input [1:0] sel, output [7:0] v);
		gvi_host_model_i.wr(1'b1, {6'b0100_00, sel});
		gvi_host_model_i.rd(1'b0, v);
	endtask
	task ackit(input v, input [7:0] e);
		@(negedge clk);
		ack = 1'b1;
		@(negedge clk);
		ack = 1'b0;
		chk("valid", {7'h00, vld}, {7'h00, v});
		if (v) chk("vector", vec, e);
	endtask
	task summarize;
		if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	////////////////////////////////////////
	initial begin
		void'($urandom(7));
		repeat (20) @(negedge clk);
		srst = 1'b0;
		gvi_host_model_i.rd(1'b1, d);
		chk("status", d, 8'h40);
		rdreg(2'd1, d);
		chk("mask", d, 8'hff);
		rdreg(2'd2, d);
		chk("latch", d, 8'h00);
		for (i = 0; i < 8; i++) begin
			vmem[i] = 8'($urandom);
			gvi_host_model_i.vect(i[2:0], vmem[i]);
		end
		gvi_host_model_i.wr(1'b1, 8'h61);
		gvi_host_model_i.wr(1'b1, 8'h80);
		gvi_host_model_i.rd(1'b1, d);
		chk("status", d, 8'h48);
		gvi_host_model_i.wr(1'b1, 8'h21);
		gvi_host_model_i.rd(1'b1, d);
		chk("status", d, 8'h68);
		gvi_host_model_i.wr(1'b1, 8'h24);
		gvi_host_model_i.rd(1'b1, d);
		chk("status", d, 8'h58);
		gvi_host_model_i.wr(1'b1, 8'h20);
		pend = 8'($urandom) | 8'h01;
		@(negedge clk);
		irq = pend;
		repeat (3) @(negedge clk);
		irq = 8'h00;
		rdreg(2'd2, d);
		chk("latch", d, pend);
		for (i = 0; i < 8 && pend != 8'h00; i++) begin
			chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h01);
			t = top(pend);
			ackit(1'b1, vmem[t]);
			pend[t] = 1'b0;
			chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h00);
			gvi_host_model_i.wr(1'b1, {5'b1111_1, t});
		end
		rdreg(2'd2, d);
		chk("latch", d, 8'h00);
		gvi_host_model_i.wr(1'b1, 8'h88);
		gvi_host_model_i.wr(1'b1, 8'hbb);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h00);
		gvi_host_model_i.wr(1'b1, 8'h93);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h01);
		rdreg(2'd1, d);
		chk("mask", d, 8'hf7);
		gvi_host_model_i.wr(1'b1, 8'h24);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h00);
		gvi_host_model_i.rd(1'b1, d);
		chk("status", d, 8'hd8);
		gvi_host_model_i.wr(1'b1, 8'h20);
		gvi_host_model_i.wr(1'b1, 8'hc8);
		gvi_host_model_i.wr(1'b0, 8'h08);
		ie = 1'b0;
		@(negedge clk);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h00);
		ie = 1'b1;
		chain = 1'b0;
		gvi_host_model_i.rd(1'b1, d);
		chk("status", d, 8'h08);
		ackit(1'b0, 8'h00);
		chain = 1'b1;
		ackit(1'b1, vmem[3]);
		rdreg(2'd0, d);
		chk("service", d, 8'h00);
		gvi_host_model_i.wr(1'b1, 8'h00);
		gvi_host_model_i.rd(1'b1, d);
		chk("status", d, 8'h40);
		gvi_host_model_i.wr(1'b1, 8'h41);
		gvi_host_model_i.rd(1'b0, d);
		chk("mask", d, 8'hff);
		gvi_host_model_i.wr(1'b1, 8'h61);
		gvi_host_model_i.wr(1'b1, 8'hc0);
		gvi_host_model_i.wr(1'b0, 8'h00);
		gvi_host_model_i.wr(1'b1, 8'h21);
		gvi_host_model_i.wr(1'b1, 8'hb9);
		gvi_host_model_i.wr(1'b1, 8'hbc);
		ackit(1'b1, vmem[1]);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h00);
		gvi_host_model_i.wr(1'b1, 8'he0);
		gvi_host_model_i.wr(1'b1, 8'h23);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h01);
		ackit(1'b1, vmem[0]);
		rdreg(2'd0, d);
		chk("service", d, 8'h10);
		gvi_host_model_i.wr(1'b1, 8'ha8);
		gvi_host_model_i.wr(1'b1, 8'hb2);
		rdreg(2'd2, d);
		chk("latch", d, 8'hfb);
		gvi_host_model_i.wr(1'b1, 8'ha0);
		gvi_host_model_i.wr(1'b1, 8'h20);
		gvi_host_model_i.wr(1'b1, 8'he0);
		gvi_host_model_i.wr(1'b1, 8'hbd);
		ackit(1'b1, vmem[5]);
		gvi_host_model_i.wr(1'b1, 8'hbe);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h00);
		gvi_host_model_i.wr(1'b1, 8'hba);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h01);
		ackit(1'b1, vmem[2]);
		gvi_host_model_i.wr(1'b1, 8'hfa);
		rdreg(2'd0, d);
		chk("service", d, 8'h20);
		chk("group_interrupt_out", {7'h00, group_interrupt_out}, 8'h00);
		summarize;
	end
endmodule // test_gvi_group
